/* File: include/ccx_pkg.sv */
// Shared constants, types and decode for the clear/call execute block.
// Assumes one MCLK cycle per instruction cycle and an APB host.
// What this block does
// RQ1: Clear-file zeroes addressed file register, sets zero
// RQ2: Call pushes current PC plus one first
// RQ3: Call loads eleven-bit target into PC low
// RQ4: Call copies holding bits 4:3 to PC 12:11
// RQ5: Call takes two cycles, discards prefetched word
// RQ6: Clear-accumulator zeroes accumulator, sets zero flag
// RQ7: Watchdog clear resets the watchdog counter
// RQ8: Watchdog clear also resets the prescaler
// RQ9: Watchdog clear sets expired_n and sleep_n bits
// RQ10: Clear ops each take one cycle, one word
// RQ11: Call leaves status flags untouched
package ccx_pkg;
	// Opcode fields
	localparam logic [6:0] OP_ZERO_FILE = 7'h03;
	localparam logic [6:0] OP_ZERO_ACC = 7'h02;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [13:0] OP_KICK_WDT = 14'h0064;
	localparam int CALL_CYCLES = 2;
	// Reset values
	localparam logic [12:0] PC_RST = 13'h0000;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// APB register offsets
	localparam logic [7:0] REG_PCHOLD = 8'h00;
	localparam logic [7:0] REG_ACC = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0c;
	localparam logic [7:0] REG_STACK = 8'h10;
	localparam logic [7:0] REG_FSEL = 8'h14;
	localparam logic [7:0] REG_FDATA = 8'h18;
	// Status field positions
	localparam int ST_Z_BIT = 0;
	localparam int ST_PD_BIT = 1;
	localparam int ST_TO_BIT = 2;

	// Execute sequencer states
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_FLUSH = 2'b10
	} ccx_state_e;

	// Decoded instruction word
	typedef struct packed {
		logic zero_file_op;
		logic zero_acc_op;
		logic call_op;
		logic kick_watchdog_op;
		logic [6:0] faddr;
		logic [10:0] target;
	} ccx_dec_s;

	// Status bits
	typedef struct packed {
		logic watchdog_expired_n;
		logic sleep_entered_n;
		logic zero;
	} ccx_stat_s;

	// Split a 14-bit word into operation flags and operands
	function automatic ccx_dec_s ccx_decode(input logic [13:0] w);
		ccx_dec_s d;
		d.zero_file_op = (w[13:7] == OP_ZERO_FILE);
		d.zero_acc_op = (w[13:7] == OP_ZERO_ACC);
		d.call_op = (w[13:11] == OP_CALL);
		d.kick_watchdog_op = (w == OP_KICK_WDT);
		d.faddr = w[6:0];
		d.target = w[10:0];
		return d;
	endfunction : ccx_decode
endpackage : ccx_pkg

/* File: rtl/ccx_file_regs.sv */
// Data-file register array, flip-flop storage.
// Assumes a single write port from the execute logic.
`timescale 1ns/100ps
module ccx_file_regs import ccx_pkg::*; #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem_q [DEPTH]; // Storage
	logic [7:0] mem_d [DEPTH]; // Next storage

	// Next contents: one byte replaced on write
	always_comb begin
		mem_d = mem_q;
		if (wr_en) begin
			mem_d[wr_addr] = wr_data;
		end
	end

	// Register the array
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= ZERO_BYTE;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	// Software view of one byte
	assign rd_data = mem_q[rd_addr];
endmodule : ccx_file_regs

/* File: rtl/ccx_ret_stack.sv */
// Circular return-address stack, push only.
// Assumes overflow simply wraps, as the core does.
`timescale 1ns/100ps
module ccx_ret_stack import ccx_pkg::*; #(
	parameter int DEPTH = 8,
	parameter int PW = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [12:0] push_data,
	output logic [12:0] head_q
);
	logic [12:0] mem_q [DEPTH]; // Entries
	logic [12:0] mem_d [DEPTH]; // Next entries
	logic [PW-1:0] ptr_q; // Top index
	logic [PW-1:0] ptr_d; // Next top index
	logic [12:0] head_d; // Next head copy

	// Push advances the pointer and writes the new top
	always_comb begin
		mem_d = mem_q;
		ptr_d = ptr_q;
		head_d = head_q;
		if (push) begin
			ptr_d = ptr_q + PW'(1);
			mem_d[ptr_d] = push_data;
			head_d = push_data;
		end
	end

	// Register pointer, entries and head copy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= '0;
			head_q <= PC_RST;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= PC_RST;
			end
		end else begin
			ptr_q <= ptr_d;
			head_q <= head_d;
			mem_q <= mem_d;
		end
	end
endmodule : ccx_ret_stack

/* File: rtl/ccx_exec.sv */
// Execute logic for clear-file, clear-accumulator, call and watchdog clear.
// Assumes one instruction word per valid MCLK cycle and an APB master.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module ccx_exec import ccx_pkg::*; (
	input wire logic MCLK,
	input wire logic RESET_N,
	// Program memory side
	input wire logic [13:0] INSTR_WORD,
	input wire logic INSTR_VALID,
	// Watchdog and sleep events from outside
	input wire logic WDT_TIMEOUT,
	input wire logic SLEEP_ENTRY,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Core state
	output logic [12:0] PC_OUT,
	output logic [7:0] ACC_OUT,
	output logic ZERO_FLAG,
	output logic WATCHDOG_EXPIRED_N,
	output logic SLEEP_ENTERED_N,
	output logic WDT_CLEAR,
	output logic [12:0] STACK_HEAD
);
	// Execute state
	ccx_state_e state_q;
	ccx_state_e state_d;
	logic [12:0] pc_q; // Fetch address
	logic [12:0] pc_d;
	logic [7:0] acc_q; // Working accumulator
	logic [7:0] acc_d;
	ccx_stat_s stat_q; // Status bits
	ccx_stat_s stat_d;
	logic kick_q; // Counter and prescaler clear pulse
	logic kick_d;
	ccx_dec_s dec; // Decoded word
	logic push; // Stack push strobe
	logic [12:0] ret_addr; // Return address
	logic fwr; // File write strobe
	logic [12:0] head; // Stack head

	// APB state
	logic [4:0] pchold_q; // Upper PC holding
	logic [4:0] pchold_d;
	logic [6:0] fsel_q; // File view select
	logic [6:0] fsel_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [7:0] fview; // Selected file byte
	logic wr_acc; // Write taken this edge
	logic mapped; // Address hits a register

	assign dec = ccx_decode(INSTR_WORD);
	assign ret_addr = pc_q + 13'h0001;

	// File register array
	ccx_file_regs #(.DEPTH(128), .AW(7)) u_file (
		.clk(MCLK),
		.rst_n(RESET_N),
		.wr_en(fwr),
		.wr_addr(dec.faddr),
		.wr_data(ZERO_BYTE),
		.rd_addr(fsel_q),
		.rd_data(fview)
	);

	// Return-address stack
	ccx_ret_stack #(.DEPTH(8), .PW(3)) u_stack (
		.clk(MCLK),
		.rst_n(RESET_N),
		.push(push),
		.push_data(ret_addr),
		.head_q(head)
	);

	// Execute next state
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		acc_d = acc_q;
		stat_d = stat_q;
		kick_d = 1'b0;
		push = 1'b0;
		fwr = 1'b0;
		// Outside events clear the active-low bits
		if (WDT_TIMEOUT) begin
			stat_d.watchdog_expired_n = 1'b0;
		end
		if (SLEEP_ENTRY) begin
			stat_d.sleep_entered_n = 1'b0;
		end
		unique case (state_q)
			ST_RUN: begin
				if (INSTR_VALID) begin
					// Every word but a call executes in one cycle
					pc_d = ret_addr; // see RQ10
					if (dec.call_op) begin
						// Push then jump, flags untouched
						push = 1'b1; // see RQ2
						pc_d[10:0] = dec.target; // see RQ3
						pc_d[12:11] = pchold_q[4:3]; // see RQ4
						state_d = ST_FLUSH; // see RQ5, RQ11
					end
					if (dec.zero_file_op) begin
						fwr = 1'b1; // see RQ1
						stat_d.zero = 1'b1; // see RQ1
					end
					if (dec.zero_acc_op) begin
						acc_d = ZERO_BYTE; // see RQ6
						stat_d.zero = 1'b1; // see RQ6
					end
					if (dec.kick_watchdog_op) begin
						// Clear pulse restarts counter and prescaler
						kick_d = 1'b1; // see RQ7, RQ8
						// Set wins over a same-cycle clear
						stat_d.watchdog_expired_n = 1'b1; // see RQ9
						stat_d.sleep_entered_n = 1'b1; // see RQ9
					end
				end
			end
			ST_FLUSH: begin
				// Stale prefetched word is dropped
				if (INSTR_VALID) begin
					state_d = ST_RUN; // see RQ5
				end
			end
		endcase
	end

	// Execute registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= ST_RUN;
			pc_q <= PC_RST;
			acc_q <= ACC_RST;
			stat_q <= 3'b110;
			kick_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			acc_q <= acc_d;
			stat_q <= stat_d;
			kick_q <= kick_d;
		end
	end

	// APB decode and read mux
	always_comb begin
		pchold_d = pchold_q;
		fsel_d = fsel_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		// One wait state, then ready
		pready_d = PSEL && PENABLE && !pready_q;
		wr_acc = PSEL && PENABLE && pready_q && PWRITE;
		mapped = 1'b1;
		unique case (PADDR)
			REG_PCHOLD: prdata_d = {27'h0, pchold_q};
			REG_ACC: prdata_d = {24'h0, acc_q};
			REG_STATUS: prdata_d = {29'h0, stat_q};
			REG_PC: prdata_d = {19'h0, pc_q};
			REG_STACK: prdata_d = {19'h0, head};
			REG_FSEL: prdata_d = {25'h0, fsel_q};
			REG_FDATA: prdata_d = {24'h0, fview};
			default: begin
				// Unmapped reads zero with error
				prdata_d = 32'h0;
				mapped = 1'b0;
			end
		endcase
		if (!pready_d) begin
			prdata_d = prdata_q;
		end
		pslverr_d = pready_d && !mapped;
		// Writes land on the ready edge
		if (wr_acc && PADDR == REG_PCHOLD) begin
			pchold_d = PWDATA[4:0];
		end
		if (wr_acc && PADDR == REG_FSEL) begin
			fsel_d = PWDATA[6:0];
		end
	end

	// APB registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pchold_q <= 5'h00;
			fsel_q <= 7'h00;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pchold_q <= pchold_d;
			fsel_q <= fsel_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Outputs straight from flops
	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign PC_OUT = pc_q;
	assign ACC_OUT = acc_q;
	assign ZERO_FLAG = stat_q.zero;
	assign WATCHDOG_EXPIRED_N = stat_q.watchdog_expired_n;
	assign SLEEP_ENTERED_N = stat_q.sleep_entered_n;
	assign WDT_CLEAR = kick_q;
	assign STACK_HEAD = head;

	// Checks on the execute behaviour
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	logic run_vld; // Word executes this cycle
	assign run_vld = INSTR_VALID && state_q == ST_RUN;

	a_zero_file_op_zero_write: assert property ( // see RQ1
		run_vld && dec.zero_file_op |=>
		u_file.mem_q[$past(dec.faddr)] == 8'h00 && ZERO_FLAG)
		else $error("file clear did not zero byte or set flag");

	a_call_push_ret: assert property ( // see RQ2
		run_vld && dec.call_op |=> STACK_HEAD == $past(pc_q) + 13'h0001)
		else $error("call pushed wrong return address");

	a_call_low_target: assert property ( // see RQ3
		run_vld && dec.call_op |=> PC_OUT[10:0] == $past(INSTR_WORD[10:0]))
		else $error("call target not in pc low bits");

	a_call_upper_bits: assert property ( // see RQ4
		run_vld && dec.call_op |=> PC_OUT[12:11] == $past(pchold_q[4:3]))
		else $error("call upper pc bits wrong");

	a_call_flush_slot: assert property ( // see RQ5
		run_vld && dec.call_op ##1 INSTR_VALID |=>
		PC_OUT == $past(PC_OUT) && $stable(ACC_OUT) && $stable(ZERO_FLAG))
		else $error("word behind call was executed");

	a_zero_acc_op_acc_zero: assert property ( // see RQ6
		run_vld && dec.zero_acc_op |=> ACC_OUT == 8'h00 && ZERO_FLAG)
		else $error("accumulator clear failed");

	a_kick_clear_pulse: assert property ( // see RQ7
		run_vld && dec.kick_watchdog_op |=>
		WDT_CLEAR ##1 (WDT_CLEAR == $past(run_vld && dec.kick_watchdog_op)))
		else $error("watchdog clear pulse wrong");

	a_kick_only_cause: assert property ( // see RQ8
		WDT_CLEAR |-> $past(run_vld && INSTR_WORD == 14'h0064))
		else $error("spurious counter and prescaler clear");

	a_kick_status_set: assert property ( // see RQ9
		run_vld && dec.kick_watchdog_op |=> WATCHDOG_EXPIRED_N && SLEEP_ENTERED_N)
		else $error("status bits not set by watchdog clear");

	a_single_cycle_op: assert property ( // see RQ10
		run_vld && !dec.call_op |=> PC_OUT == $past(pc_q) + 13'h0001 && state_q == ST_RUN)
		else $error("clear op not single cycle");

	a_call_keeps_flag: assert property ( // see RQ11
		run_vld && dec.call_op |=> $stable(ZERO_FLAG))
		else $error("call changed zero flag");

	// Only a call moves the stack head
	a_stack_call_only: assert property ( // see RQ2
		run_vld && !dec.call_op |=> $stable(STACK_HEAD))
		else $error("stack moved without a call");

	// A call always opens the dropped slot
	a_call_enters_flush: assert property ( // see RQ5
		run_vld && dec.call_op |=> state_q == ST_FLUSH)
		else $error("call did not enter flush slot");

	// The dropped slot leaves stack and accumulator alone
	a_flush_no_effect: assert property ( // see RQ5
		state_q == ST_FLUSH |=> $stable(STACK_HEAD) && $stable(ACC_OUT))
		else $error("flushed slot changed state");

	// File clear must not touch the accumulator
	a_zero_file_op_keeps_acc: assert property ( // see RQ1
		run_vld && dec.zero_file_op |=> $stable(ACC_OUT))
		else $error("file clear changed accumulator");

	// A stalled fetch holds PC and accumulator and raises no clear pulse
	a_stall_holds_state: assert property ( // see RQ10
		!INSTR_VALID |=> $stable(PC_OUT) && $stable(ACC_OUT) && !WDT_CLEAR)
		else $error("state changed while fetch stalled");

	// Watchdog clear only touches the two active-low bits
	a_kick_keeps_acc: assert property ( // see RQ9
		run_vld && dec.kick_watchdog_op |=> $stable(ACC_OUT) && $stable(ZERO_FLAG))
		else $error("watchdog clear changed accumulator or zero");

	// Call keeps the active-low status bits when no event arrives
	a_call_status_hold: assert property ( // see RQ11
		run_vld && dec.call_op && !WDT_TIMEOUT && !SLEEP_ENTRY |=>
		$stable(WATCHDOG_EXPIRED_N) && $stable(SLEEP_ENTERED_N))
		else $error("call changed status bits");
endmodule : ccx_exec

/* File: verif/ccx_pmem.sv */
// Program memory model that feeds instruction words to the execute block.
// Assumes the bench fills the store before it raises run.
`timescale 1ns/100ps
module ccx_pmem (
	input wire logic [12:0] pc,
	input wire logic run,
	output logic [13:0] word,
	output logic valid
);
	// Word store, all zero words decode as no-operation
	logic [13:0] mem [0:8191];
	// Word at the fetch address, offered while running
	assign word = mem[pc];
	assign valid = run;
	// Clear the store so no fetch returns unknown bits
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 14'h0000;
		end
	end
endmodule : ccx_pmem

/* File: verif/clear_and_call_execute_bench.sv */
// Self-checking bench for the clear, call and watchdog-clear execute block.
// Assumes one instruction word per MCLK and the APB map of the package.
`timescale 1ns/100ps
module clear_and_call_execute_bench import ccx_pkg::*;;
	logic mclk = 1'b0, reset_n = 1'b0, run = 1'b0, wdt_to = 1'b0, sleep_in = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, wdt_clr, zero, exp_n, slp_n, valid;
	logic [13:0] word;
	logic [12:0] pc, head;
	logic [7:0] acc;
	int miscompares = 0, tests_run = 0;

	// Program memory model on the fetch side
	ccx_pmem pm_u (.pc(pc), .run(run), .word(word), .valid(valid));
	// Block under test
	ccx_exec dut_u (.MCLK(mclk), .RESET_N(reset_n), .INSTR_WORD(word), .INSTR_VALID(valid),
		.WDT_TIMEOUT(wdt_to), .SLEEP_ENTRY(sleep_in), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PC_OUT(pc), .ACC_OUT(acc), .ZERO_FLAG(zero),
		.WATCHDOG_EXPIRED_N(exp_n), .SLEEP_ENTERED_N(slp_n), .WDT_CLEAR(wdt_clr),
		.STACK_HEAD(head));

	// 100 MHz clock
	initial begin
		forever #5 mclk = ~mclk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Print counts and verdict, then end the run
	task automatic stop_test();
		$display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	// Hold reset for eight cycles with fetch stopped
	task automatic do_reset();
		run <= 1'b0;
		reset_n <= 1'b0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
	endtask : do_reset

	// One clock, then let the edge's updates land
	task automatic step();
		@(posedge mclk);
		#1;
	endtask : step

	// One APB transfer; read data and error land in rd and err
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Wait for the ready edge; only the watchdog ends a hang
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Clear file 5, call with holding bits 11, kick at the target, dropped once then run
	task automatic test_call();
		do_reset();
		pm_u.mem[0] = 14'h0185;
		pm_u.mem[1] = 14'h2155;
		pm_u.mem[13'h1955] = OP_KICK_WDT;
		apb(1'b1, REG_PCHOLD, 32'h18);
		apb(1'b1, REG_FSEL, 32'h5);
		wdt_to <= 1'b1;
		sleep_in <= 1'b1;
		@(posedge mclk);
		wdt_to <= 1'b0;
		sleep_in <= 1'b0;
		run <= 1'b1;
		step();
		chk({exp_n, slp_n, zero, pc}, {3'b001, 13'h1});
		step();
		chk({zero, head, pc}, {1'b1, 13'h2, 13'h1955});
		step();
		chk({wdt_clr, exp_n, pc}, {2'b00, 13'h1955});
		step();
		chk({wdt_clr, exp_n, slp_n, pc}, {3'b111, 13'h1956});
		step();
		chk(wdt_clr, 1'b0);
		@(posedge mclk);
		run <= 1'b0;
		apb(1'b0, REG_PC, 32'h0);
		chk(rd, 32'h1958);
		apb(1'b0, REG_STACK, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, REG_PCHOLD, 32'h0);
		chk(rd, 32'h18);
		apb(1'b0, REG_FDATA, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
	endtask : test_call

	// Clear accumulator with all don't-care bits set
	task automatic test_zero_acc_op();
		do_reset();
		pm_u.mem[0] = 14'h017f;
		step();
		chk({zero, exp_n, slp_n, wdt_clr, acc, pc}, {4'b0110, 8'h00, 13'h0});
		@(posedge mclk);
		run <= 1'b1;
		step();
		chk({zero, acc, pc}, {1'b1, 8'h00, 13'h1});
		@(posedge mclk);
		run <= 1'b0;
		apb(1'b0, REG_ACC, 32'h0);
		chk(rd, 32'h0);
	endtask : test_zero_acc_op

	// Main sequence
	initial begin
		test_call();
		test_zero_acc_op();
		stop_test();
	end

	// Watchdog against a hang
	initial begin
		#50000;
		miscompares++;
		stop_test();
	end
endmodule : clear_and_call_execute_bench
